// ===== verilog/aps_regs.svh
// register map, field positions, reset values and timing counts
// assumes a 20 MHz ref_clk and an external 1 ms tick
`ifndef APS_REGS_SVH
`define APS_REGS_SVH
`define APS_CTRL_OFS 8'h00
`define APS_WTR_OFS 8'h04
`define APS_RTO_OFS 8'h08
`define APS_STAT_OFS 8'h0c
`define APS_RXK_OFS 8'h10
`define APS_CTRL_REV 0
`define APS_CTRL_BIDIR 1
`define APS_CTRL_OPT 2
`define APS_CTRL_SDH 3
`define APS_CTRL_MAN 4
`define APS_CTRL_RST 5'h02
`define APS_WTR_RST 16'h012c
`define APS_RTO_RST 16'h0032
`define APS_ST_SEL 0
`define APS_ST_PRIM 1
`define APS_ST_ALM 2
`define APS_ST_DEF 6
`define APS_ST_PSBEV 10
`define APS_ST_MODE 11
`define APS_AL_PSB 0
`define APS_AL_CM 1
`define APS_AL_MM 2
`define APS_AL_FEPL 3
`define APS_RAISE_MS 2500
`define APS_CLEAR_MS 10000
`define CHANNEL_MISMATCH_FAILURE_MS 50
`define MODE_MISMATCH_FAILURE_MS 100
`define APS_RUN_FRAMES 3
`define APS_WIN_FRAMES 12
`define APS_REQ_SF_SONET 4'hc
`define APS_REQ_SF_SDH 4'hd
`define APS_REQ_SD_SONET 4'ha
`define APS_REQ_SD_SDH 4'hb
`define APS_REQ_RR 4'h2
`define APS_REQ_WTR 4'h6
`define APS_REQ_DNR 4'h1
`define APS_REQ_NR 4'h0
`define APS_REQ_MAN 4'h8
`define APS_K2_BIDIR 3'h5
`define APS_K2_UNI 3'h4
`define APS_K2_SDH 3'h0
`endif

// ===== verilog/aps_pkg.sv
// types shared by the protection switch controller
// assumes aps_regs.svh on the include path
`include "aps_regs.svh"
package aps_pkg;
   typedef logic [7:0] aps_kbyte_type;
   typedef enum logic [1:0] {
      aps_norm = 2'b00,
      aps_wtr = 2'b01,
      aps_wait_rr = 2'b10
   } aps_mode_type;
   // request code valid for a 1+1 group in the chosen flavour
   function automatic logic aps_k1_used(input logic [3:0] req, input logic sdh);
      case (req)
         4'hf, 4'he, 4'h8, 4'h6, 4'h4, 4'h2, 4'h1, 4'h0: aps_k1_used = 1'b1;
         `APS_REQ_SF_SONET, `APS_REQ_SD_SONET: aps_k1_used = !sdh;
         `APS_REQ_SF_SDH, `APS_REQ_SD_SDH: aps_k1_used = sdh;
         default: aps_k1_used = 1'b0;
      endcase
   endfunction
   function automatic logic aps_is_sf(input logic [3:0] req, input logic sdh);
      aps_is_sf = req == (sdh ? `APS_REQ_SF_SDH : `APS_REQ_SF_SONET);
   endfunction
   function automatic logic aps_is_sd(input logic [3:0] req, input logic sdh);
      aps_is_sd = req == (sdh ? `APS_REQ_SD_SDH : `APS_REQ_SD_SONET);
   endfunction
endpackage

// ===== verilog/aps_dbn_if.sv
// defect and alarm pair between controller and debouncer
// assumes one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
interface aps_dbn_if;
   logic defect;
   logic alarm;
   modport ctl (output defect, input alarm);
   modport dbn (input defect, output alarm);
endinterface
`default_nettype wire

// ===== verilog/aps_dbn.sv
// debounce of one defect into an alarm, counted in ms ticks
// assumes ms_tick is a one-cycle pulse in the ref_clk domain
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.svh"
module aps_dbn #(
   parameter int RAISE_MS = `APS_RAISE_MS,
   parameter int CLEAR_MS = `APS_CLEAR_MS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // time base
   input wire logic ms_tick,
   // defect in, alarm out
   aps_dbn_if.dbn io
);
   import aps_pkg::*;
   typedef struct packed {
      logic alarm;
      logic [13:0] cnt;
   } aps_dbn_type;
   aps_dbn_type q;
   aps_dbn_type next_q;
   always_comb
   begin
      next_q = q;
      if (io.defect == q.alarm)
      begin
         next_q.cnt = 14'h0000;
      end
      else if (ms_tick)
      begin
         if (q.cnt == 14'((q.alarm ? CLEAR_MS : RAISE_MS) - 1))
         begin
            next_q.alarm = io.defect;
            next_q.cnt = 14'h0000;
         end
         else
         begin
            next_q.cnt = q.cnt + 14'h0001;
         end
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= next_q;
   end
   assign io.alarm = q.alarm;
   a_dbn_raise: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(q.alarm) |-> $past(io.defect) && $past(ms_tick)
         && $past(q.cnt) == 14'(RAISE_MS - 1)) else $error("alarm raised early");
   a_dbn_restart: assert property (@(posedge ref_clk) disable iff (!rst_b)
      io.defect == q.alarm |=> q.cnt == 14'h0000) else $error("count not restarted");
endmodule
`default_nettype wire

// ===== verilog/aps_k1_hist.sv
// received K1 history: runs of identical bytes per frame
// assumes frame_tick is a one-cycle pulse with rx_k1 valid
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.svh"
module aps_k1_hist (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // received byte
   input wire logic frame_tick,
   input wire aps_pkg::aps_kbyte_type rx_k1,
   // results
   output logic stable,
   output aps_pkg::aps_kbyte_type stable_val,
   output logic incons
);
   import aps_pkg::*;
   typedef struct packed {
      aps_kbyte_type prev;
      logic [1:0] run;
      logic [3:0] gap;
      logic stable;
      aps_kbyte_type val;
      logic incons;
   } aps_hist_type;
   aps_hist_type q;
   aps_hist_type next_q;
   always_comb
   begin
      next_q = q;
      if (frame_tick)
      begin
         next_q.prev = rx_k1;
         if (rx_k1 != q.prev || q.run == 2'h0)
            next_q.run = 2'h1;
         else if (q.run != 2'(`APS_RUN_FRAMES))
            next_q.run = q.run + 2'h1;
         next_q.stable = next_q.run == 2'(`APS_RUN_FRAMES);
         if (next_q.stable)
         begin
            next_q.val = rx_k1;
            next_q.gap = 4'h0;
         end
         else if (q.gap != 4'(`APS_WIN_FRAMES))
         begin
            next_q.gap = q.gap + 4'h1;
         end
         next_q.incons = next_q.gap == 4'(`APS_WIN_FRAMES);
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= next_q;
   end
   assign stable = q.stable;
   assign stable_val = q.val;
   assign incons = q.incons;
endmodule
`default_nettype wire

// ===== verilog/aps_switch.sv
// 1+1 line protection switch controller with K-byte defect monitor
// assumes synchronous frame and ms ticks, APB master on ref_clk
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.svh"
module aps_switch (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // line side
   input wire logic frame_tick,
   input wire logic ms_tick,
   input wire aps_pkg::aps_kbyte_type rx_k1,
   input wire aps_pkg::aps_kbyte_type rx_k2,
   input wire logic sf_w,
   input wire logic sd_w,
   input wire logic sf_p,
   input wire logic sd_p,
   // transmit and selection
   output aps_pkg::aps_kbyte_type tx_k1,
   output aps_pkg::aps_kbyte_type tx_k2,
   output logic sel_prot,
   output logic pay_en_w,
   output logic pay_en_p,
   output logic kb_en_w,
   output logic [3:0] alarm
);
   import aps_pkg::*;
   typedef struct packed {
      logic [4:0] ctrl;
      logic [15:0] wtr_cfg;
      logic [15:0] rto_cfg;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic sel;
      logic prim;
      logic psf_q;
      aps_mode_type mode;
      logic [15:0] tmr;
      logic psb_ev;
      aps_kbyte_type tx_k1;
      aps_kbyte_type tx_k2;
      aps_kbyte_type rx_k2;
      logic [1:0] tx_run;
      logic pay_w;
      logic pay_p;
      logic kb_w;
      logic [3:0] alarm;
   } aps_core_type;
   aps_core_type q;
   aps_core_type next_q;
   logic k1_stable;
   aps_kbyte_type k1_val;
   logic k1_incons;
   logic [3:0] def;
   logic cm_raw;
   logic cm_def;
   logic rev;
   logic bidir;
   logic opt;
   logic sdh;
   logic rreq;
   logic rr_seen;
   logic psf;
   logic ssf;
   logic want;
   logic want_p;
   logic [3:0] req;
   logic [3:0] chan;
   logic acc;
   logic [3:0] alm;
   aps_dbn_if dbn[4] ();
   aps_dbn_if cm_if ();
   assign rev = q.ctrl[`APS_CTRL_REV];
   assign bidir = q.ctrl[`APS_CTRL_BIDIR] || opt;
   assign opt = q.ctrl[`APS_CTRL_OPT];
   assign sdh = q.ctrl[`APS_CTRL_SDH];
   aps_k1_hist u_hist (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .frame_tick(frame_tick),
      .rx_k1(rx_k1),
      .stable(k1_stable),
      .stable_val(k1_val),
      .incons(k1_incons)
   );
   // defects
   assign def[`APS_AL_PSB] = k1_incons
      || (k1_stable && (!aps_k1_used(k1_val[7:4], sdh) || k1_val[3:0] > 4'h1));
   assign cm_raw = q.tx_run == 2'(`APS_RUN_FRAMES)
      && q.rx_k2[7:4] != q.tx_k1[3:0];
   assign cm_if.defect = cm_raw;
   assign cm_def = cm_if.alarm;
   assign def[`APS_AL_CM] = cm_def;
   assign def[`APS_AL_MM] = q.rx_k2[3]
      || (!sdh && bidir && q.rx_k2[2:0] == `APS_K2_UNI);
   assign def[`APS_AL_FEPL] = k1_stable && aps_is_sf(k1_val[7:4], sdh)
      && k1_val[3:0] == 4'h0;
   aps_dbn #(
      .RAISE_MS(`CHANNEL_MISMATCH_FAILURE_MS + 1),
      .CLEAR_MS(1)
   ) u_cm (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ms_tick(ms_tick),
      .io(cm_if.dbn)
   );
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_alm
         // only the mode alarm may rise outside bidirectional operation
         assign dbn[gi].defect = def[gi] && (bidir || gi == `APS_AL_MM);
         aps_dbn u_dbn (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .ms_tick(ms_tick),
            .io(dbn[gi].dbn)
         );
         assign alm[gi] = dbn[gi].alarm;
      end
   endgenerate
   // remote request on the working channel and reverse request seen
   assign rreq = bidir && k1_stable && k1_val[3:0] == 4'h1
      && (aps_is_sf(k1_val[7:4], sdh) || aps_is_sd(k1_val[7:4], sdh));
   assign rr_seen = k1_stable && k1_val[7:4] == `APS_REQ_RR;
   assign psf = q.prim ? sf_p : sf_w;
   assign ssf = q.prim ? sf_w : sf_p;
   assign acc = psel && penable && q.pready;
   // selection wanted for plain 1+1
   always_comb
   begin
      want = 1'b1;
      want_p = 1'b0;
      if (def[`APS_AL_FEPL])
         want_p = 1'b0;
      else if (sf_w && sf_p)
         want_p = 1'b0;
      else if (sf_w)
         want_p = 1'b1;
      else if (sf_p)
         want_p = 1'b0;
      else if (sd_w && sd_p)
         want_p = q.sel;
      else if (sd_w)
         want_p = 1'b1;
      else if (sd_p)
         want_p = 1'b0;
      else if (rreq)
         want_p = 1'b1;
      else if (q.ctrl[`APS_CTRL_MAN])
         want_p = 1'b1;
      else
         want = 1'b0;
   end
   // transmitted request code and channel
   always_comb
   begin
      chan = 4'h1;
      if (sf_w && !def[`APS_AL_FEPL])
         req = sdh ? `APS_REQ_SF_SDH : `APS_REQ_SF_SONET;
      else if (sf_p)
      begin
         req = sdh ? `APS_REQ_SF_SDH : `APS_REQ_SF_SONET;
         chan = 4'h0;
      end
      else if (sd_w)
         req = sdh ? `APS_REQ_SD_SDH : `APS_REQ_SD_SONET;
      else if (sd_p)
      begin
         req = sdh ? `APS_REQ_SD_SDH : `APS_REQ_SD_SONET;
         chan = 4'h0;
      end
      else if (rreq)
         req = `APS_REQ_RR;
      else if (q.ctrl[`APS_CTRL_MAN])
         req = `APS_REQ_MAN;
      else if (q.mode == aps_wtr)
         req = `APS_REQ_WTR;
      else if (q.sel && (!rev || opt))
         req = `APS_REQ_DNR;
      else
      begin
         req = `APS_REQ_NR;
         chan = 4'h0;
      end
   end
   always_comb
   begin
      next_q = q;
      next_q.alarm = alm;
      // apb: data staged in setup, answered in the first access cycle
      next_q.pready = psel && !penable;
      next_q.pslverr = 1'b0;
      if (psel && !penable)
      begin
         next_q.prdata = 32'h00000000;
         case (paddr)
            `APS_CTRL_OFS: next_q.prdata[4:0] = q.ctrl;
            `APS_WTR_OFS: next_q.prdata[15:0] = q.wtr_cfg;
            `APS_RTO_OFS: next_q.prdata[15:0] = q.rto_cfg;
            `APS_STAT_OFS:
            begin
               next_q.prdata[`APS_ST_SEL] = q.sel;
               next_q.prdata[`APS_ST_PRIM] = q.prim;
               next_q.prdata[`APS_ST_ALM +: 4] = q.alarm;
               next_q.prdata[`APS_ST_DEF +: 4] = def;
               next_q.prdata[`APS_ST_PSBEV] = q.psb_ev;
               next_q.prdata[`APS_ST_MODE +: 2] = q.mode;
            end
            `APS_RXK_OFS: next_q.prdata[15:0] = {q.rx_k2, k1_val};
            default: next_q.pslverr = 1'b1;
         endcase
      end
      if (acc && pwrite)
      begin
         case (paddr)
            `APS_CTRL_OFS: next_q.ctrl = pwdata[4:0];
            `APS_WTR_OFS: next_q.wtr_cfg = pwdata[15:0];
            `APS_RTO_OFS: next_q.rto_cfg = pwdata[15:0];
            `APS_STAT_OFS:
               if (pwdata[`APS_ST_PSBEV])
                  next_q.psb_ev = 1'b0;
            default: next_q.psb_ev = q.psb_ev;
         endcase
      end
      if (frame_tick)
      begin
         next_q.rx_k2 = rx_k2;
         next_q.tx_k1 = {req, chan};
         if ({req, chan} != q.tx_k1)
            next_q.tx_run = 2'h1;
         else if (q.tx_run != 2'(`APS_RUN_FRAMES))
            next_q.tx_run = q.tx_run + 2'h1;
         next_q.tx_k2[7:4] = {3'h0, q.sel};
         next_q.tx_k2[3] = 1'b0;
         next_q.tx_k2[2:0] = sdh ? `APS_K2_SDH
            : (bidir ? `APS_K2_BIDIR : `APS_K2_UNI);
      end
      next_q.psf_q = psf;
      if (opt)
      begin
         next_q.pay_w = !q.sel;
         next_q.pay_p = q.sel;
         next_q.kb_w = 1'b1;
         case (q.mode)
            aps_wait_rr:
               if (rr_seen)
                  next_q.mode = aps_norm;
               else if (ms_tick)
               begin
                  if (q.tmr <= 16'h0001)
                  begin
                     next_q.psb_ev = 1'b1;
                     next_q.sel = q.prim;
                     next_q.mode = aps_norm;
                  end
                  else
                     next_q.tmr = q.tmr - 16'h0001;
               end
            default:
            begin
               next_q.mode = aps_norm;
               if (psf && !q.psf_q && q.sel == q.prim)
               begin
                  next_q.sel = !q.prim;
                  next_q.mode = aps_wait_rr;
                  next_q.tmr = q.rto_cfg;
               end
               else if (ssf && q.sel != q.prim)
                  next_q.sel = q.prim;
               else if (rreq && q.sel == q.prim)
                  next_q.sel = !q.prim;
               else if (!psf && !rreq && q.sel != q.prim)
                  next_q.prim = q.sel;
            end
         endcase
      end
      else
      begin
         next_q.pay_w = 1'b1;
         next_q.pay_p = 1'b1;
         next_q.kb_w = 1'b0;
         next_q.prim = 1'b0;
         case (q.mode)
            aps_wtr:
               if (want)
               begin
                  next_q.mode = aps_norm;
                  next_q.sel = want_p;
               end
               else if (!rev)
                  next_q.mode = aps_norm;
               else if (ms_tick)
               begin
                  if (q.tmr <= 16'h0001)
                  begin
                     next_q.sel = 1'b0;
                     next_q.mode = aps_norm;
                  end
                  else
                     next_q.tmr = q.tmr - 16'h0001;
               end
            default:
            begin
               next_q.mode = aps_norm;
               if (want)
                  next_q.sel = want_p;
               else if (q.sel && rev)
               begin
                  next_q.mode = aps_wtr;
                  next_q.tmr = q.wtr_cfg;
               end
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         q <= '0;
         q.ctrl <= `APS_CTRL_RST;
         q.wtr_cfg <= `APS_WTR_RST;
         q.rto_cfg <= `APS_RTO_RST;
      end
      else
         q <= next_q;
   end
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign tx_k1 = q.tx_k1;
   assign tx_k2 = q.tx_k2;
   assign sel_prot = q.sel;
   assign pay_en_w = q.pay_w;
   assign pay_en_p = q.pay_p;
   assign kb_en_w = q.kb_w;
   assign alarm = q.alarm;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence s_wait_rr;
      opt && q.mode == aps_wait_rr && !rr_seen && ms_tick && q.tmr <= 16'h0001;
   endsequence
   sequence s_back_prim;
      q.sel == $past(q.prim) && q.psb_ev && q.mode == aps_norm;
   endsequence
   a_fepl_work: assert property (!opt && def[`APS_AL_FEPL] |=> !q.sel)
      else $error("far-end fail did not force working");
   a_both_sf: assert property (!opt && sf_w && sf_p |=> !q.sel)
      else $error("double fail not on working");
   a_nonrev_hold: assert property (!opt && !rev && !want && q.sel |=> q.sel)
      else $error("non-revertive left protection");
   a_wtr_load: assert property (!opt && q.mode == aps_norm && !want && q.sel && rev
      |=> q.mode == aps_wtr && q.tmr == $past(q.wtr_cfg))
      else $error("restore wait not loaded");
   a_sf_code: assert property (frame_tick && sf_w && !def[`APS_AL_FEPL]
      |=> q.tx_k1[7:4] == (sdh ? 4'hd : 4'hc))
      else $error("wrong signal fail code");
   a_k2_mode: assert property (frame_tick |=> q.tx_k2[3] == 1'b0
      && q.tx_k2[2:0] == (sdh ? 3'h0 : (bidir ? 3'h5 : 3'h4)))
      else $error("wrong K2 mode bits");
   a_rr_answer: assert property (frame_tick && !opt && rreq && !sf_w && !sf_p
      && !sd_w && !sd_p && !def[`APS_AL_FEPL] |=> q.sel && q.tx_k1[7:4] == 4'h2)
      else $error("no reverse request answer");
   a_opt_payload: assert property (opt ##1 opt |-> pay_en_w != pay_en_p && kb_en_w)
      else $error("optimized payload or K bytes wrong");
   a_rr_timeout: assert property (s_wait_rr |=> s_back_prim)
      else $error("reverse request timeout not handled");
   a_cm_after_run: assert property ($rose(cm_def) |-> $past(cm_raw, 1))
      else $error("channel mismatch without cause");
endmodule
`default_nettype wire

// ===== verif/aps_far_end.sv
// far-end line terminal model answering the near end's K bytes
// assumes SONET flavour; bench override replaces both bytes for faults
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.svh"
module aps_far_end (
   // clock
   input wire logic ref_clk,
   // near-end transmit
   input wire aps_pkg::aps_kbyte_type tx_k1,
   // bench override
   input wire logic ovr,
   input wire aps_pkg::aps_kbyte_type ovr_k1,
   input wire aps_pkg::aps_kbyte_type ovr_k2,
   // far-end transmit
   output aps_pkg::aps_kbyte_type rx_k1,
   output aps_pkg::aps_kbyte_type rx_k2
);
   import aps_pkg::*;
   logic hard_req;
   initial
   begin
      rx_k1 = 8'h00;
      rx_k2 = 8'h05;
   end
   // signal fail or degrade of either flavour
   assign hard_req = tx_k1[7:4] inside {4'ha, 4'hb, 4'hc, 4'hd};
   always @(posedge ref_clk)
   begin
      rx_k1 <= ovr ? ovr_k1 : (hard_req ? {`APS_REQ_RR, tx_k1[3:0]} : 8'h00);
      rx_k2 <= ovr ? ovr_k2 : {tx_k1[3:0], 1'b0, `APS_K2_BIDIR};
   end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for aps_switch with far-end model
// assumes design sources and aps_far_end compiled first
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; \
   $display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
   import aps_pkg::*;
   logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, state = 32'hc50871d4;
   logic frame_tick = 0, ms_tick = 0, sf_w = 0, sd_w = 0, sf_p = 0, sd_p = 0, ovr = 0;
   logic sel_prot, pay_en_w, pay_en_p, kb_en_w;
   logic [3:0] alarm;
   aps_kbyte_type rx_k1, rx_k2, tx_k1, tx_k2, ovr_k1 = 0, ovr_k2 = 0;
   logic [64:0] notes[$];
   logic [64:0] nt;
   int errors = 0, samples_checked = 0, cyc = 0, w;
   aps_switch dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .frame_tick, .ms_tick, .rx_k1, .rx_k2, .sf_w, .sd_w, .sf_p, .sd_p,
      .tx_k1, .tx_k2, .sel_prot, .pay_en_w, .pay_en_p, .kb_en_w, .alarm);
   aps_far_end far (.ref_clk, .tx_k1, .ovr, .ovr_k1, .ovr_k2, .rx_k1, .rx_k2);
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      frame_tick <= cyc % 8 == 0;
      ms_tick <= cyc % 2 == 0;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // read results: oldest note is {slverr, mask, expected}
   always @(posedge ref_clk)
      if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
      begin
         nt = notes.pop_front();
         `CHK("prdata", nt[31:0], prdata & nt[63:32])
         `CHK("pslverr", nt[64], pslverr)
      end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, m,
      input logic e);
      int n;
      @(posedge ref_clk);
      if (!wr) notes.push_back({e, m, d});
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic frm(input aps_kbyte_type k1, k2, input int n);
      ovr <= 1;
      ovr_k1 <= k1;
      ovr_k2 <= k2;
      wt(8 * n);
   endtask
   task complete_run;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      wt(60000);
      errors++;
      complete_run();
   end
   initial
   begin
      wt(10);
      rst_b <= 1;
      apb(0, `APS_CTRL_OFS, 32'h2, 32'h1f, 0);
      apb(0, `APS_WTR_OFS, 32'h12c, 32'hffff, 0);
      apb(0, `APS_RTO_OFS, 32'h32, 32'hffff, 0);
      apb(0, 8'h14, 32'h0, 32'hffffffff, 1);
      frm(8'h00, 8'h15, 30);
      apb(0, `APS_STAT_OFS, 32'h80, 32'h80, 0);
      ovr <= 0;
      wt(80);
      sf_w <= 1;
      wt(40);
      `CHK("tx_k1", 8'hc1, tx_k1)
      apb(0, `APS_STAT_OFS, 32'h1, 32'h1, 0);
      sf_p <= 1;
      wt(40);
      apb(0, `APS_STAT_OFS, 32'h0, 32'h1, 0);
      sf_p <= 0;
      wt(40);
      sf_w <= 0;
      wt(400);
      apb(0, `APS_STAT_OFS, 32'h1, 32'h1, 0);
      state = xs(state);
      w = 20 + state[3:0];
      apb(1, `APS_CTRL_OFS, 32'h3, 0, 0);
      apb(1, `APS_WTR_OFS, w, 0, 0);
      sf_w <= 1;
      wt(40);
      sf_w <= 0;
      wt(10);
      apb(1, `APS_WTR_OFS, 32'hffff, 0, 0);
      wt(w);
      apb(0, `APS_STAT_OFS, 32'h1, 32'h1, 0);
      wt(2 * w + 60);
      apb(0, `APS_STAT_OFS, 32'h0, 32'h1, 0);
      sd_w <= 1;
      wt(40);
      `CHK("tx_k1", 8'ha1, tx_k1)
      apb(0, `APS_STAT_OFS, 32'h0, 32'h40, 0);
      sd_w <= 0;
      apb(1, `APS_CTRL_OFS, 32'h2, 0, 0);
      frm(8'hc0, 8'h05, 5);
      apb(0, `APS_STAT_OFS, 32'h200, 32'h201, 0);
      frm(8'h00, 8'h05, 5);
      frm(8'h31, 8'h05, 4);
      apb(0, `APS_STAT_OFS, 32'h40, 32'h40, 0);
      frm(8'h00, 8'h05, 16);
      apb(0, `APS_STAT_OFS, 32'h0, 32'h40, 0);
      for (int i = 0; i < 13; i++)
      begin
         state = xs(state);
         frm(state[7:0], 8'h05, 1);
      end
      apb(0, `APS_STAT_OFS, 32'h40, 32'h40, 0);
      frm(8'h00, 8'h0c, 4);
      apb(0, `APS_STAT_OFS, 32'h100, 32'h100, 0);
      wt(4800);
      `CHK("alarm_mm", 1'b0, alarm[2])
      wt(400);
      `CHK("alarm_mm", 1'b1, alarm[2])
      apb(0, `APS_STAT_OFS, 32'h10, 32'h10, 0);
      frm(8'h00, 8'h05, 1);
      wt(19700);
      `CHK("alarm_mm", 1'b1, alarm[2])
      wt(600);
      `CHK("alarm_mm", 1'b0, alarm[2])
      apb(1, `APS_CTRL_OFS, 32'h6, 0, 0);
      wt(10);
      `CHK("kb_en_w", 1'b1, kb_en_w)
      `CHK("pay_en", 1'b1, pay_en_w ^ pay_en_p)
      complete_run();
   end
endmodule
`default_nettype wire
